//--- inc/xexec_pkg.sv
/*
  constants and types for the extended-instruction execution subset.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package xexec_pkg;
  // operation select codes
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SUB_TO_MEM = 4'h1,
    OP_NIB_EXCH_MEM = 4'h2,
    OP_NIB_EXCH_ACC = 4'h3,
    OP_SKIP_BYTE_NULL = 4'h4,
    OP_COPY_SKIP_NULL = 4'h5,
    OP_SKIP_BIT_NULL = 4'h6,
    OP_PAGED_TBL = 4'h7,
    OP_LAST_PAGE_TBL = 4'h8,
    OP_PREINC_PAGED_TBL = 4'h9,
    OP_PREINC_LAST_TBL = 4'ha,
    OP_EXOR_ACC = 4'hb,
    OP_EXOR_MEM = 4'hc
  } op_t;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_DUMMY = 2'b10
  } state_t;
  // status flag positions in the flag word
  localparam int FLAG_NULL = 0;
  localparam int FLAG_BORROW = 1;
  localparam int FLAG_HALF = 2;
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_SBORROW = 4;
  localparam int FLAG_CNULL = 5;
  localparam int FLAG_W = 6;
  // program memory address width
  localparam int PADDR_W = 16;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  // final program page
  localparam logic [7:0] LAST_PAGE = 8'hff;
  // cycles of a taken skip
  localparam int SKIP_CYCLES = 3;
endpackage
`default_nettype wire

//--- src/xexec_alu.sv
/*
  combinational datapath for the execution subset.
  assumes operands are stable while op is presented.
*/
`timescale 1ns/100ps
`default_nettype none
module xexec_alu (
  input wire xexec_pkg::op_t op, // operation select
  input wire logic [7:0] acc, // accumulator value
  input wire logic [7:0] mem, // data-memory operand
  input wire logic [2:0] bit_sel, // bit index for bit test
  input wire logic [5:0] flags_in, // present flags
  output logic [7:0] res, // result byte
  output logic [5:0] flags_out, // next flags
  output logic skip // skip condition
);
  import xexec_pkg::*;

  logic [8:0] diff;
  logic [4:0] ldiff;

  // subtraction and logic results
  always_comb begin
    diff = {1'b0, acc} - {1'b0, mem};
    ldiff = {1'b0, acc[3:0]} - {1'b0, mem[3:0]};
    res = mem;
    flags_out = flags_in;
    skip = 1'b0;
    case (op)
      OP_SUB_TO_MEM: begin
        res = diff[7:0]; // [RULE1]
        flags_out[FLAG_BORROW] = ~diff[8]; // [RULE1]
        flags_out[FLAG_HALF] = ~ldiff[4];
        flags_out[FLAG_WRAP] = (acc[7] ^ mem[7]) & (acc[7] ^ diff[7]);
        flags_out[FLAG_NULL] = (diff[7:0] == 8'h00);
        flags_out[FLAG_SBORROW] = diff[7] ^ flags_out[FLAG_WRAP];
        flags_out[FLAG_CNULL] = (diff[7:0] == 8'h00);
      end
      OP_NIB_EXCH_MEM, OP_NIB_EXCH_ACC: begin
        res = {mem[3:0], mem[7:4]}; // [RULE2] [RULE3]
      end
      OP_SKIP_BYTE_NULL: skip = (mem == 8'h00); // [RULE4]
      OP_COPY_SKIP_NULL: skip = (mem == 8'h00); // [RULE6]
      OP_SKIP_BIT_NULL: skip = ~mem[bit_sel]; // [RULE7]
      OP_EXOR_ACC, OP_EXOR_MEM: begin
        res = acc ^ mem; // [RULE12] [RULE13]
        flags_out[FLAG_NULL] = ((acc ^ mem) == 8'h00);
      end
      default: res = mem;
    endcase
  end
endmodule // xexec_alu
`default_nettype wire

//--- src/xexec_core.sv
/*
  execution of the extended subset: subtract, swap, skip tests,
  table reads and exclusive-or. assumes data and program memory
  answer combinationally in the cycle their address is presented.
*/
// What this block does
// RULE1: acc minus mem to memory; borrow clear when negative; six flags.
// RULE2: nibble exchange in memory swaps byte halves in place, flags kept.
// RULE3: nibble exchange to acc loads swapped byte; memory, flags kept.
// RULE4: byte zero test writes the byte back and skips if it is zero.
// RULE5: a taken skip adds a fetch and a dummy cycle, three cycles in all.
// RULE6: copy-and-test loads acc with the byte, skips if zero, flags kept.
// RULE7: bit zero test skips if the chosen bit is zero, nothing else changes.
// RULE8: paged read at page:low pointer; low byte to memory, high to latch.
// RULE9: last-page read at final page:low pointer, same destinations.
// RULE10: pre-increment paged read bumps the low pointer, then reads.
// RULE11: pre-increment last-page read bumps the low pointer, then reads.
// RULE12: exclusive-or to acc stores acc xor mem in acc, null flag only.
// RULE13: exclusive-or to memory stores acc xor mem in memory, null flag only.
// RULE14: the pre-increment wraps in eight bits, no carry into the page.
`timescale 1ns/100ps
`default_nettype none
module xexec_core (
  input wire logic clk, // 125 mhz core clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic start, // one-cycle request with op
  input wire xexec_pkg::op_t op, // operation select
  input wire logic [7:0] mem_rdata, // data-memory operand
  input wire logic [2:0] bit_sel, // bit index
  input wire logic [7:0] table_page_pointer, // page pointer
  input wire logic [15:0] prog_rdata, // program word
  output logic [xexec_pkg::PADDR_W-1:0] prog_addr, // program address
  output logic mem_we, // data-memory write strobe
  output logic [7:0] mem_wdata, // data-memory write byte
  output logic [7:0] acc, // accumulator
  output logic [5:0] flags, // status flags
  output logic [7:0] table_low_pointer, // low pointer
  output logic [7:0] table_high_latch, // high byte latch
  output logic skip_taken, // pulse when skip is taken
  output logic busy // instruction in progress
);
  import xexec_pkg::*;

  typedef struct packed {
    state_t st;
    logic [7:0] acc;
    logic [5:0] flags;
    logic [7:0] tlp;
    logic [7:0] thl;
    logic [7:0] wdata;
    logic we;
    logic skipped;
  } core_t;

  core_t s_r, s_nxt;
  logic [7:0] alu_res;
  logic [5:0] alu_flags;
  logic alu_skip;

  xexec_alu u_alu (
    .op(op),
    .acc(s_r.acc),
    .mem(mem_rdata),
    .bit_sel(bit_sel),
    .flags_in(s_r.flags),
    .res(alu_res),
    .flags_out(alu_flags),
    .skip(alu_skip)
  );

  // table pointer as used by this cycle's fetch
  function automatic logic [7:0] next_low(input op_t o, input logic [7:0] p);
    if (o == OP_PREINC_PAGED_TBL || o == OP_PREINC_LAST_TBL) begin
      next_low = p + 8'h01; // [RULE10] [RULE11] [RULE14]
    end else begin
      next_low = p;
    end
  endfunction

  logic [7:0] low_now;

  // program address: page or last page over the low pointer
  always_comb begin
    low_now = next_low(op, s_r.tlp);
    if (op == OP_LAST_PAGE_TBL || op == OP_PREINC_LAST_TBL) begin
      prog_addr = {LAST_PAGE, low_now}; // [RULE9] [RULE11]
    end else begin
      prog_addr = {table_page_pointer, low_now}; // [RULE8] [RULE10]
    end
  end

  // instruction sequencing and state update
  always_comb begin
    s_nxt = s_r;
    s_nxt.we = 1'b0;
    s_nxt.skipped = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (start) begin
          s_nxt.flags = alu_flags; // [RULE1] [RULE12] [RULE13]
          case (op)
            OP_SUB_TO_MEM, OP_NIB_EXCH_MEM, OP_EXOR_MEM: begin
              s_nxt.we = 1'b1; // [RULE1] [RULE2] [RULE13]
              s_nxt.wdata = alu_res;
            end
            OP_NIB_EXCH_ACC, OP_EXOR_ACC: s_nxt.acc = alu_res; // [RULE3]
            OP_SKIP_BYTE_NULL: begin
              s_nxt.we = 1'b1; // [RULE4]
              s_nxt.wdata = mem_rdata;
            end
            OP_COPY_SKIP_NULL: s_nxt.acc = mem_rdata; // [RULE6]
            OP_PAGED_TBL, OP_LAST_PAGE_TBL, OP_PREINC_PAGED_TBL,
            OP_PREINC_LAST_TBL: begin
              s_nxt.tlp = low_now; // [RULE14]
              s_nxt.we = 1'b1; // [RULE8] [RULE9]
              s_nxt.wdata = prog_rdata[7:0];
              s_nxt.thl = prog_rdata[15:8];
            end
            default: s_nxt.we = 1'b0;
          endcase
          if (alu_skip) begin
            s_nxt.st = ST_FETCH; // [RULE5]
            s_nxt.skipped = 1'b1;
          end
        end
      end
      ST_FETCH: s_nxt.st = ST_DUMMY; // [RULE5]
      ST_DUMMY: s_nxt.st = ST_IDLE;
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '{st: ST_IDLE, acc: ACC_RST, flags: FLAGS_RST, tlp: PTR_RST,
               thl: PTR_RST, wdata: 8'h00, we: 1'b0, skipped: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign acc = s_r.acc;
  assign flags = s_r.flags;
  assign table_low_pointer = s_r.tlp;
  assign table_high_latch = s_r.thl;
  assign mem_we = s_r.we;
  assign mem_wdata = s_r.wdata;
  assign skip_taken = s_r.skipped;
  assign busy = (s_r.st != ST_IDLE);

  // taken skip keeps the block busy for two further cycles
  skip_len_a: assert property ( // [RULE5]
    @(posedge clk) disable iff (!reset_n)
    skip_taken |-> busy ##1 busy ##1 !busy)
    else $error("skip did not last three cycles");
  // subtract writes the difference
  sub_write_a: assert property ( // [RULE1]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_SUB_TO_MEM) |=> 
      (mem_we && mem_wdata == $past(acc) - $past(mem_rdata)))
    else $error("subtract result wrong");
  // swap in memory leaves flags
  swap_mem_a: assert property ( // [RULE2]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_NIB_EXCH_MEM) |=>
      (mem_we && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
       && $stable(flags)))
    else $error("nibble exchange wrong");
  // swap to acc
  swap_acc_a: assert property ( // [RULE3]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_NIB_EXCH_ACC) |=>
      (acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && !mem_we))
    else $error("swap to acc wrong");
  // zero byte skips
  byte_skip_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_SKIP_BYTE_NULL) |=>
      (skip_taken == ($past(mem_rdata) == 8'h00)))
    else $error("byte zero skip wrong");
  // byte zero test writes the byte back and keeps flags
  byte_wback_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_SKIP_BYTE_NULL) |=>
      (mem_we && mem_wdata == $past(mem_rdata) && $stable(flags)))
    else $error("byte zero write-back wrong");
  // copy and test
  copy_skip_a: assert property ( // [RULE6]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_COPY_SKIP_NULL) |=>
      (acc == $past(mem_rdata) && $stable(flags)))
    else $error("copy and test wrong");
  // bit test
  bit_skip_a: assert property ( // [RULE7]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_SKIP_BIT_NULL) |=>
      (skip_taken == !$past(mem_rdata[bit_sel]) && !mem_we))
    else $error("bit zero skip wrong");
  // table read latches
  tbl_latch_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_PAGED_TBL) |=>
      (table_high_latch == $past(prog_rdata[15:8])
       && mem_wdata == $past(prog_rdata[7:0])))
    else $error("table read wrong");
  // last-page read addresses the final page
  last_addr_a: assert property ( // [RULE9]
    @(posedge clk) disable iff (!reset_n)
    (op == OP_LAST_PAGE_TBL) |->
      (prog_addr == {LAST_PAGE, table_low_pointer}))
    else $error("last page address wrong");
  // pre-increment paged read uses the bumped pointer
  pre_paged_a: assert property ( // [RULE10]
    @(posedge clk) disable iff (!reset_n)
    (op == OP_PREINC_PAGED_TBL) |->
      (prog_addr == {table_page_pointer, table_low_pointer + 8'h01}))
    else $error("pre-increment paged address wrong");
  // pre-increment last-page read uses the bumped pointer
  pre_last_a: assert property ( // [RULE11]
    @(posedge clk) disable iff (!reset_n)
    (op == OP_PREINC_LAST_TBL) |->
      (prog_addr == {LAST_PAGE, table_low_pointer + 8'h01}))
    else $error("pre-increment last page address wrong");
  // pre-increment wraps alone
  preinc_wrap_a: assert property ( // [RULE14]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_PREINC_LAST_TBL) |=>
      (table_low_pointer == $past(table_low_pointer) + 8'h01))
    else $error("pointer increment wrong");
  // xor to acc
  exor_acc_a: assert property ( // [RULE12]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_EXOR_ACC) |=>
      (acc == ($past(acc) ^ $past(mem_rdata))
       && flags[FLAG_NULL] == (acc == 8'h00)))
    else $error("xor to acc wrong");
  // xor to memory
  exor_mem_a: assert property ( // [RULE13]
    @(posedge clk) disable iff (!reset_n)
    (start && !busy && op == OP_EXOR_MEM) |=>
      (mem_we && mem_wdata == ($past(acc) ^ $past(mem_rdata))
       && flags[FLAG_NULL] == (mem_wdata == 8'h00)))
    else $error("xor to memory wrong");
endmodule // xexec_core
`default_nettype wire

//--- test/tb_xexec_core.sv
/*
  self-checking bench for xexec_core: subtract, swaps, skips, table reads
  and exclusive-or. assumes the package and core sources compile first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_xexec_core;
  import xexec_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  op_t op = OP_NONE;
  logic [7:0] mem_rdata = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] table_page_pointer = 8'h12;
  logic [15:0] prog_rdata, prog_addr, pa;
  logic mem_we, skip_taken, busy;
  logic [7:0] mem_wdata, acc, table_low_pointer, table_high_latch, ea, ep;
  logic [5:0] flags, ef;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // program memory answers with a word derived from its address
  function automatic logic [15:0] pword(input logic [15:0] a);
    return {~a[7:0], a[15:8] ^ 8'h3c};
  endfunction
  assign prog_rdata = pword(prog_addr);
  xexec_core dut (.clk(clk), .reset_n(reset_n), .start(start), .op(op),
    .mem_rdata(mem_rdata), .bit_sel(bit_sel),
    .table_page_pointer(table_page_pointer), .prog_rdata(prog_rdata),
    .prog_addr(prog_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .acc(acc), .flags(flags), .table_low_pointer(table_low_pointer),
    .table_high_latch(table_high_latch), .skip_taken(skip_taken),
    .busy(busy));
  always #4 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request once the core is idle; returns after results land
  task automatic issue(input op_t o, input logic [7:0] m,
                       input logic [2:0] b);
    while (busy !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    mem_rdata <= m;
    bit_sel <= b;
    #1 pa = prog_addr;
    @(posedge clk);
    start <= 1'b0;
    #1;
  endtask
  // skip pulse, busy span, and a start during busy that must be ignored
  task automatic skipchk(input logic exp);
    chk("skip_taken", exp, skip_taken);
    chk("busy", exp, busy);
    if (exp) begin
      @(posedge clk);
      start <= 1'b1;
      op <= OP_EXOR_ACC;
      mem_rdata <= 8'hff;
      #1 chk("busy", 1'b1, busy);
      chk("skip_taken", 1'b0, skip_taken);
      @(posedge clk);
      start <= 1'b0;
      #1 chk("busy", 1'b0, busy);
      chk("acc", ea, acc);
    end
  endtask
  task automatic t_sub(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] r;
    logic ov;
    issue(OP_COPY_SKIP_NULL, a, 3'h0);
    ea = a;
    chk("acc", ea, acc);
    skipchk(1'b0);
    r = a - m;
    ov = (a[7] != m[7]) && (r[7] != a[7]);
    ef = {r == 8'h00, r[7] ^ ov, ov, a[3:0] >= m[3:0], a >= m, r == 8'h00};
    issue(OP_SUB_TO_MEM, m, 3'h0);
    chk("mem_we", 1'b1, mem_we);
    chk("mem_wdata", r, mem_wdata);
    chk("flags", ef, flags);
    chk("acc", ea, acc);
  endtask
  task automatic t_tbl(input op_t o, input logic inc, input logic last);
    logic [15:0] e;
    if (inc) ep = ep + 8'h01;
    e = {last ? LAST_PAGE : 8'h12, ep};
    issue(o, 8'h00, 3'h0);
    chk("prog_addr", e, pa);
    chk("table_low_pointer", ep, table_low_pointer);
    chk("mem_we", 1'b1, mem_we);
    chk("mem_wdata", pword(e) & 16'h00ff, mem_wdata);
    chk("table_high_latch", pword(e) >> 8, table_high_latch);
    chk("flags", ef, flags);
  endtask
  // reset values, then release
  task automatic t_reset();
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk("acc", ACC_RST, acc);
    chk("flags", FLAGS_RST, flags);
    chk("table_low_pointer", PTR_RST, table_low_pointer);
    chk("table_high_latch", PTR_RST, table_high_latch);
    chk("busy", 1'b0, busy);
    ep = PTR_RST;
  endtask
  // nibble exchanges keep flags
  task automatic t_swap();
    issue(OP_NIB_EXCH_MEM, 8'ha5, 3'h0);
    chk("mem_we", 1'b1, mem_we);
    chk("mem_wdata", 8'h5a, mem_wdata);
    chk("flags", ef, flags);
    issue(OP_NIB_EXCH_ACC, 8'h3c, 3'h0);
    ea = 8'hc3;
    chk("acc", ea, acc);
    chk("mem_we", 1'b0, mem_we);
    chk("flags", ef, flags);
  endtask
  // byte and bit tests, taken and not
  task automatic t_skip();
    issue(OP_SKIP_BYTE_NULL, 8'h00, 3'h0);
    chk("mem_wdata", 8'h00, mem_wdata);
    chk("mem_we", 1'b1, mem_we);
    skipchk(1'b1);
    issue(OP_SKIP_BYTE_NULL, 8'h05, 3'h0);
    chk("mem_wdata", 8'h05, mem_wdata);
    skipchk(1'b0);
    issue(OP_COPY_SKIP_NULL, 8'h00, 3'h0);
    ea = 8'h00;
    chk("acc", ea, acc);
    skipchk(1'b1);
    issue(OP_SKIP_BIT_NULL, 8'hf7, 3'h3);
    chk("mem_we", 1'b0, mem_we);
    skipchk(1'b1);
    issue(OP_SKIP_BIT_NULL, 8'hf7, 3'h2);
    skipchk(1'b0);
    chk("flags", ef, flags);
  endtask
  // table reads, then wrap the low pointer
  task automatic t_tbls();
    t_tbl(OP_PAGED_TBL, 1'b0, 1'b0);
    t_tbl(OP_LAST_PAGE_TBL, 1'b0, 1'b1);
    t_tbl(OP_PREINC_PAGED_TBL, 1'b1, 1'b0);
    t_tbl(OP_PREINC_LAST_TBL, 1'b1, 1'b1);
    for (int i = 0; i < 255; i++) begin
      t_tbl(OP_PREINC_PAGED_TBL, 1'b1, 1'b0);
    end
  endtask
  // exclusive-or touches only the null flag
  task automatic t_exor();
    issue(OP_EXOR_ACC, 8'h0f, 3'h0);
    ea = ea ^ 8'h0f;
    ef[FLAG_NULL] = (ea == 8'h00);
    chk("acc", ea, acc);
    chk("flags", ef, flags);
    chk("mem_we", 1'b0, mem_we);
    issue(OP_EXOR_MEM, ea, 3'h0);
    ef[FLAG_NULL] = 1'b1;
    chk("mem_we", 1'b1, mem_we);
    chk("mem_wdata", 8'h00, mem_wdata);
    chk("flags", ef, flags);
    chk("acc", ea, acc);
  endtask
  initial begin
    t_reset();
    t_sub(8'h30, 8'h50);
    t_sub(8'h50, 8'h50);
    t_sub(8'h13, 8'h04);
    t_sub(8'h80, 8'h01);
    t_swap();
    t_skip();
    t_tbls();
    t_exor();
    finish_test();
  end
endmodule // tb_xexec_core
`default_nettype wire
